// *** hw/amcs_pkg.sv ***
package amcs_pkg;
  // ---------------------------------------------------------------
  // Widths and values
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] COUNT_START = 8'h01;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [1:0] CMD_ENABLE = 2'h0;
  localparam logic [1:0] CMD_RANDOM = 2'h1;
  localparam logic [1:0] CMD_SEQUENTIAL = 2'h2;
  localparam int SW_LOW_MSB = 3;
  localparam int SW_HIGH_LSB = 4;
  localparam int SPLIT_BIT = 4;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] module_sel_n;
    logic [3:0] pair_sel_n;
  } amcs_select_t;

  typedef struct packed {
    logic inhibit_a;
    logic inhibit_b;
  } amcs_split_t;
endpackage

// *** hw/amcs_sequencer.sv ***
`timescale 1ns/1ps
// Contract
// - Sequential command sets mode latch
// - Random command clears mode latch
// - Transfer-out latch arms buffer load
// - Data ready loads buffer, resets counter
// - Comparator true while count below final
// - Load sets count 1, clock adds one
// - Busy assertion makes counter clock pulse
// - End-of-scan set the cycle after the final clock pulse
// - Next conversion after scan end restarts count
// - Sense strobe returns end-of-scan state
// - Inverted end-of-scan output for interrupts
// - Random load from ready and transfer/enable
// - Random load copies buffer to latches
// - Random mode compare/scan flag meaningless
// - Low nibble pair, high nibble module
// - Split jumper: bit E inhibits pair half
// - Blanking pulse on every sequential counter clock or random-mode load
// - Blank from load or conversion clock
// - Select outputs active low
// - Enable command: random plus block transfer
module amcs_sequencer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic system_reset,
  input wire logic external_control_instr,
  input wire logic [1:0] control_code,
  input wire logic sense_test_instr,
  input wire logic transfer_out_start,
  input wire logic transfer_out_done,
  input wire logic data_ready_pulse,
  input wire logic [7:0] bus_data_bit_low,
  input wire logic busy,
  input wire logic split_pair_jumper,
  output logic sense_return_line,
  output logic end_of_scan_n,
  output logic compare_true,
  output logic sequential_mode,
  output logic block_transfer_enable,
  output logic transfer_out_latch,
  output logic blanking,
  output amcs_pkg::amcs_select_t select,
  output amcs_pkg::amcs_split_t split_inhibit,
  output logic [7:0] channel_count
);
  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [2:0] ready_sync;
  logic [2:0] busy_sync;
  logic [7:0] channel_address_buffer;
  logic end_of_scan;
  logic load_pulse;
  logic clk_pulse;
  logic [7:0] data_sync_a;
  logic [7:0] data_sync_b;
  logic clk_seen;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_sync <= 3'h0;
      busy_sync <= 3'h0;
      data_sync_a <= amcs_pkg::ADDR_RESET;
      data_sync_b <= amcs_pkg::ADDR_RESET;
    end else begin
      ready_sync <= {ready_sync[1:0], data_ready_pulse};
      busy_sync <= {busy_sync[1:0], busy};
      // Address bits ride the same two stages as ready
      data_sync_a <= bus_data_bit_low;
      data_sync_b <= data_sync_a;
    end
  end

  // Leading edges of the synchronised levels
  assign clk_pulse = busy_sync[1] & ~busy_sync[2];
  assign load_pulse = ready_sync[1] & ~ready_sync[2] &
                      (transfer_out_latch | block_transfer_enable);

  // ---------------------------------------------------------------
  // Mode and transfer latches
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sequential_mode <= 1'b0;
      block_transfer_enable <= 1'b0;
    end else if (system_reset) begin
      sequential_mode <= 1'b0;
      block_transfer_enable <= 1'b0;
    end else if (external_control_instr) begin
      if (control_code == amcs_pkg::CMD_SEQUENTIAL) begin
        sequential_mode <= 1'b1;
        block_transfer_enable <= 1'b0;
      end else if (control_code == amcs_pkg::CMD_RANDOM) begin
        sequential_mode <= 1'b0;
        block_transfer_enable <= 1'b0;
      end else if (control_code == amcs_pkg::CMD_ENABLE) begin
        sequential_mode <= 1'b0;
        block_transfer_enable <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transfer_out_latch <= 1'b0;
    end else if (transfer_out_start) begin
      transfer_out_latch <= 1'b1;
    end else if (transfer_out_done || system_reset) begin
      transfer_out_latch <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Buffer register and channel counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_address_buffer <= amcs_pkg::ADDR_RESET;
    end else if (load_pulse) begin
      channel_address_buffer <= data_sync_b;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_count <= amcs_pkg::ADDR_RESET;
    end else if (load_pulse && !sequential_mode) begin
      channel_count <= data_sync_b;
    end else if (load_pulse) begin
      channel_count <= amcs_pkg::COUNT_START;
    end else if (clk_pulse && sequential_mode && end_of_scan) begin
      channel_count <= amcs_pkg::COUNT_START;
    end else if (clk_pulse && sequential_mode) begin
      channel_count <= 8'(channel_count + 8'h01);
    end
  end

  // Compare and scan flag carry no meaning in random mode
  assign compare_true = channel_count < channel_address_buffer;

  // ---------------------------------------------------------------
  // End of scan
  // ---------------------------------------------------------------
  // Set once the clocked count reaches the final address
  logic count_at_final;
  assign count_at_final = (channel_count == channel_address_buffer);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      end_of_scan <= 1'b0;
    end else if (sequential_mode && clk_pulse && end_of_scan) begin
      end_of_scan <= 1'b0;
    end else if (sequential_mode && !clk_pulse && !load_pulse && count_at_final
                 && !end_of_scan && clk_seen) begin
      end_of_scan <= 1'b1;
    end else if (load_pulse && sequential_mode) begin
      end_of_scan <= 1'b0;
    end
  end

  // Marks a counter clock since the last load
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_seen <= 1'b0;
    end else if (load_pulse) begin
      clk_seen <= 1'b0;
    end else if (clk_pulse && sequential_mode) begin
      clk_seen <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sense_return_line <= 1'b0;
      end_of_scan_n <= 1'b1;
    end else begin
      sense_return_line <= sense_test_instr & end_of_scan;
      end_of_scan_n <= ~end_of_scan;
    end
  end

  // ---------------------------------------------------------------
  // Switch drive
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blanking <= 1'b0;
    end else begin
      blanking <= sequential_mode ? clk_pulse : load_pulse;
    end
  end

  always_comb begin
    select.pair_sel_n = ~channel_count[amcs_pkg::SW_LOW_MSB:0];
    select.module_sel_n = ~channel_count[7:amcs_pkg::SW_HIGH_LSB];
    split_inhibit.inhibit_a = split_pair_jumper & channel_count[amcs_pkg::SPLIT_BIT];
    split_inhibit.inhibit_b = split_pair_jumper & ~channel_count[amcs_pkg::SPLIT_BIT];
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_seq_load;
    sequential_mode && load_pulse;
  endsequence

  AST_SEQ_SET: assert property (@(posedge clock) disable iff (!rst_n)
    external_control_instr && control_code == amcs_pkg::CMD_SEQUENTIAL && !system_reset
    |=> sequential_mode) else $error("sequential command ignored");
  AST_RND_CLR: assert property (@(posedge clock) disable iff (!rst_n)
    external_control_instr && control_code == amcs_pkg::CMD_RANDOM
    |=> !sequential_mode) else $error("random command ignored");
  AST_LOAD_BUF: assert property (@(posedge clock) disable iff (!rst_n)
    load_pulse |=> channel_address_buffer == $past(data_sync_b))
    else $error("buffer not loaded");
  AST_SEQ_START: assert property (@(posedge clock) disable iff (!rst_n)
    s_seq_load |=> channel_count == amcs_pkg::COUNT_START) else $error("count not one");
  AST_COUNT_INC: assert property (@(posedge clock) disable iff (!rst_n)
    sequential_mode && clk_pulse && !load_pulse && !end_of_scan
    |=> channel_count == $past(channel_count) + 8'h01) else $error("count not advanced");
  AST_COMPARE: assert property (@(posedge clock) disable iff (!rst_n)
    count_at_final |-> !compare_true) else $error("compare true at final");
  AST_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    sequential_mode && clk_pulse && end_of_scan && !load_pulse
    |=> channel_count == amcs_pkg::COUNT_START) else $error("no restart");
  AST_RND_COPY: assert property (@(posedge clock) disable iff (!rst_n)
    load_pulse && !sequential_mode |=> channel_count == channel_address_buffer)
    else $error("random copy missing");
  AST_BLANK: assert property (@(posedge clock) disable iff (!rst_n)
    sequential_mode && clk_pulse |=> blanking) else $error("no blanking");
  AST_SENSE: assert property (@(posedge clock) disable iff (!rst_n)
    sense_test_instr |=> sense_return_line == $past(end_of_scan))
    else $error("sense wrong");

  // ---------------------------------------------------------------
  // Checks on mode and transfer latches
  // ---------------------------------------------------------------
  AST_SYS_RST: assert property (@(posedge clock) disable iff (!rst_n)
    system_reset |=> !sequential_mode) else $error("system reset kept sequential mode");
  AST_MODE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    sequential_mode && !system_reset && !external_control_instr |=> sequential_mode)
    else $error("sequential mode dropped without a command");
  AST_RND_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    !sequential_mode && !(external_control_instr && control_code == amcs_pkg::CMD_SEQUENTIAL)
    |=> !sequential_mode) else $error("random mode left without a command");
  AST_BTE_SET: assert property (@(posedge clock) disable iff (!rst_n)
    external_control_instr && control_code == amcs_pkg::CMD_ENABLE && !system_reset
    |=> block_transfer_enable && !sequential_mode) else $error("enable command ignored");
  AST_TOL_SET: assert property (@(posedge clock) disable iff (!rst_n)
    transfer_out_start |=> transfer_out_latch) else $error("transfer-out latch not set");
  AST_TOL_CLR: assert property (@(posedge clock) disable iff (!rst_n)
    transfer_out_done && !transfer_out_start |=> !transfer_out_latch)
    else $error("transfer-out latch not cleared");
  AST_REFUSE: assert property (@(posedge clock) disable iff (!rst_n)
    ready_sync[1] && !ready_sync[2] && !transfer_out_latch && !block_transfer_enable
    |=> $stable(channel_address_buffer)) else $error("unqualified ready loaded buffer");

  // ---------------------------------------------------------------
  // Checks on counter and end of scan
  // ---------------------------------------------------------------
  sequence s_busy_rise;
    !busy_sync[1] ##1 busy_sync[1];
  endsequence

  sequence s_final_clock;
    sequential_mode && clk_pulse && !load_pulse && !end_of_scan
    ##1 sequential_mode && count_at_final && !clk_pulse && !load_pulse;
  endsequence

  AST_CLK_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
    s_busy_rise |-> clk_pulse) else $error("busy rise made no counter clock");
  AST_CLK_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    s_busy_rise |=> !clk_pulse) else $error("counter clock longer than one cycle");
  AST_RND_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !sequential_mode && !load_pulse |=> $stable(channel_count))
    else $error("count moved without a load in random mode");
  AST_EOS_SET: assert property (@(posedge clock) disable iff (!rst_n)
    s_final_clock |=> end_of_scan) else $error("end of scan not set");
  AST_EOS_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    s_seq_load |=> !end_of_scan) else $error("end of scan kept over a new load");
  AST_EOS_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    sequential_mode && clk_pulse && end_of_scan |=> !end_of_scan)
    else $error("end of scan kept over a restart");

  // ---------------------------------------------------------------
  // Checks on switch drive and status outputs
  // ---------------------------------------------------------------
  AST_RND_BLANK: assert property (@(posedge clock) disable iff (!rst_n)
    !sequential_mode && load_pulse |=> blanking) else $error("no blanking on random load");
  AST_BLANK_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_pulse && !load_pulse |=> !blanking) else $error("blanking without a new selection");
  AST_SPLIT: assert property (@(posedge clock) disable iff (!rst_n)
    split_pair_jumper |-> split_inhibit.inhibit_a != split_inhibit.inhibit_b)
    else $error("split jumper inhibits no half");
  AST_NO_SPLIT: assert property (@(posedge clock) disable iff (!rst_n)
    !split_pair_jumper |-> !split_inhibit.inhibit_a && !split_inhibit.inhibit_b)
    else $error("half inhibited without split jumper");
  AST_EOS_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    end_of_scan |=> !end_of_scan_n) else $error("inverted end of scan stays high");
  AST_EOS_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    !end_of_scan |=> end_of_scan_n) else $error("inverted end of scan stays low");
  AST_SENSE_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    !sense_test_instr |=> !sense_return_line) else $error("sense line without sense");
endmodule // amcs_sequencer

// *** sim/amcs_adc_model.sv ***
`timescale 1ns/1ps
module amcs_adc_model (
  input wire logic clock,
  input wire logic start,
  output logic busy
);
  int remain = 0;
  initial busy = 1'b0;
  // Busy high 4 cycles from conversion start, then low 4
  always @(posedge clock) begin
    if (start && remain == 0) remain <= 8;
    else if (remain > 0) remain <= remain - 1;
    busy <= (remain > 4);
  end
endmodule // amcs_adc_model

// *** sim/amcs_sequencer_tb.sv ***
`timescale 1ns/1ps
module amcs_sequencer_tb;
  logic clock = 0, rst_n = 0, sys_rst = 0, ext = 0, sense = 0, jumper = 0;
  logic to_start = 0, to_done = 0, ready = 0, start = 0, busy;
  logic [1:0] code = 2'h0;
  logic [7:0] data = 8'h00;
  logic sense_ret, eos_n, cmp, seq, bte, tol, blank;
  amcs_pkg::amcs_select_t sel;
  amcs_pkg::amcs_split_t sp;
  logic [7:0] count;
  int err_count = 0, tests_run = 0, blanks = 0, b0;
  always #10 clock = ~clock;
  always @(posedge clock) if (blank === 1'b1) blanks++;
  amcs_sequencer i_dut (.clock(clock), .rst_n(rst_n), .system_reset(sys_rst),
    .external_control_instr(ext), .control_code(code), .sense_test_instr(sense),
    .transfer_out_start(to_start), .transfer_out_done(to_done),
    .data_ready_pulse(ready), .bus_data_bit_low(data), .busy(busy),
    .split_pair_jumper(jumper), .sense_return_line(sense_ret),
    .end_of_scan_n(eos_n), .compare_true(cmp), .sequential_mode(seq),
    .block_transfer_enable(bte), .transfer_out_latch(tol), .blanking(blank),
    .select(sel), .split_inhibit(sp), .channel_count(count));
  amcs_adc_model i_adc (.clock(clock), .start(start), .busy(busy));
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic command(logic [1:0] c);
    code = c;
    ext = 1;
    step(1);
    ext = 0;
    step(2);
  endtask
  task automatic load(logic [7:0] a, logic prog);
    if (prog) begin
      to_start = 1;
      step(1);
      to_start = 0;
      step(1);
      check(tol, 8'h01);
    end
    data = a;
    ready = 1;
    step(4);
    ready = 0;
    step(6);
    data = ~a;
    to_done = prog;
    step(1);
    to_done = 0;
    step(1);
  endtask
  task automatic wait_busy(logic lvl);
    int i;
    for (i = 0; busy !== lvl; i++) begin
      if (i == 20) begin
        err_count++;
        final_report();
      end
      step(1);
    end
  endtask
  task automatic convert();
    start = 1;
    step(1);
    start = 0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    step(6);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    step(16);
    rst_n = 1;
    step(2);
    check(eos_n, 8'h01);
    check(sel, 8'hFF);
    command(amcs_pkg::CMD_SEQUENTIAL);
    check(seq, 8'h01);
    load(8'h03, 1);
    check(count, 8'h01);
    check(cmp, 8'h01);
    check(eos_n, 8'h01);
    b0 = blanks;
    convert();
    check(count, 8'h02);
    convert();
    check(count, 8'h03);
    check(cmp, 8'h00);
    check(eos_n, 8'h00);
    check(8'(blanks - b0), 8'h02);
    sense = 1;
    step(2);
    check(sense_ret, 8'h01);
    sense = 0;
    convert();
    check(count, 8'h01);
    command(amcs_pkg::CMD_RANDOM);
    check(seq, 8'h00);
    b0 = blanks;
    load(8'hA5, 1);
    check(count, 8'hA5);
    check(sel, 8'h5A);
    check(8'(blanks - b0), 8'h01);
    convert();
    check(count, 8'hA5);
    load(8'h3C, 0);
    check(count, 8'hA5);
    command(amcs_pkg::CMD_ENABLE);
    check(bte, 8'h01);
    load(8'h3C, 0);
    check(count, 8'h3C);
    jumper = 1;
    step(1);
    check(8'(sp.inhibit_a ^ sp.inhibit_b), 8'h01);
    command(amcs_pkg::CMD_SEQUENTIAL);
    load(8'h02, 1);
    convert();
    check(count, 8'h02);
    check(eos_n, 8'h00);
    load(8'h05, 1);
    check(eos_n, 8'h01);
    check(cmp, 8'h01);
    sense = 1;
    step(2);
    check(sense_ret, 8'h00);
    sense = 0;
    sys_rst = 1;
    step(1);
    sys_rst = 0;
    step(2);
    check(seq, 8'h00);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    final_report();
  end
endmodule // amcs_sequencer_tb
